//--- rtl/mcast_proxy.sv
/*
 * Multicast proxy: per-interface subscription table, merged membership
 * table, upstream report engine, querier tick and forwarding decision.
 * Assumes an external parser delivers decoded listener reports and
 * packet headers, and a framer turns reports and queries into messages.
 */
`timescale 1ns/1ps
module mcast_proxy #(
    parameter int TICK_CYC = mcast_pkg::TICK_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic en,
    input wire logic ev_valid,
    output logic ev_ready,
    input wire logic [mcast_pkg::CW-1:0] ev_ifc,
    input wire logic [mcast_pkg::AW-1:0] ev_group,
    input wire logic ev_v1,
    input wire logic ev_excl,
    input wire logic ev_leave,
    input wire logic [mcast_pkg::AW-1:0] ev_src,
    input wire logic ev_src_ok,
    input wire logic uq_valid,
    input wire logic up_v1,
    output logic rp_valid,
    input wire logic rp_ready,
    output logic [mcast_pkg::AW-1:0] rp_group,
    output logic rp_excl,
    output logic [mcast_pkg::NCFI-1:0] rp_src_ok,
    output logic [mcast_pkg::NCFI-1:0][mcast_pkg::AW-1:0] rp_src,
    output logic rp_solicited,
    output logic rp_v1,
    output logic [mcast_pkg::NCFI-1:0] qry_pulse,
    input wire logic pk_valid,
    output logic pk_ready,
    input wire logic [mcast_pkg::IW-1:0] pk_ifc,
    input wire logic [mcast_pkg::AW-1:0] pk_dst,
    input wire logic [mcast_pkg::AW-1:0] pk_src,
    input wire logic pk_mld,
    output logic fwd_valid,
    input wire logic fwd_ready,
    output logic [mcast_pkg::NCFI:0] fwd_mask,
    output logic fwd_local
);
    localparam int NC = mcast_pkg::NCFI;
    localparam int NS = mcast_pkg::NSLOT;
    localparam int AW = mcast_pkg::AW;

    logic [NC-1:0][NS-1:0] val_q, v1_q, excl_q, sok_q;
    logic [AW-1:0] src_q [NC][NS];
    logic [8:0] gt_q [NC][NS];
    logic [8:0] st_q [NC][NS];
    logic [AW-1:0] grp_q [NS];
    logic [NS-1:0] used, ev_hit, pk_hit, chg, on_q, un_q, so_q, pend, sent;
    logic [mcast_pkg::SW-1:0] ev_sel, rk;
    logic ev_take, tick, load, pk_take, pop, lnk, site, xf, xok, loc_d;
    logic [AW-1:0] xs;
    logic [NC-1:0] mem;
    logic [NC:0] mask_d;
    mcast_pkg::mrec_t mdb_d [NS];
    mcast_pkg::mrec_t mdb_q [NS];
    logic [31:0] tcnt_q;
    logic [8:0] qcnt_q;
    logic [NC:0] fb_mask_q [2];
    logic [1:0] fb_loc_q;
    logic wp_q, rdp_q;
    logic [1:0] cnt_q;
    logic rp_valid_q, rp_excl_q, rp_sol_q, rp_v1_q;
    logic [AW-1:0] rp_group_q;
    logic [NC-1:0] rp_ok_q;
    logic [NC-1:0][AW-1:0] rp_src_q;
    logic [NC-1:0] qry_q;

    // slots currently holding the given group on any interface
    function automatic logic [NS-1:0] hit_of(input logic [AW-1:0] a);
        logic [NS-1:0] h;
        h = '0;
        for (int k = 0; k < NS; k++) begin
            h[k] = used[k] && grp_q[k] == a;
        end
        return h;
    endfunction

    // index of the lowest set bit
    function automatic logic [mcast_pkg::SW-1:0] first(input logic [NS-1:0] m);
        logic [mcast_pkg::SW-1:0] r;
        r = '0;
        for (int k = NS - 1; k >= 0; k--) begin
            if (m[k]) begin
                r = mcast_pkg::SW'(k);
            end
        end
        return r;
    endfunction

    // slot allocation: the group table is shared, membership is per interface
    always_comb begin
        for (int k = 0; k < NS; k++) begin
            used[k] = 1'b0;
            for (int i = 0; i < NC; i++) begin
                used[k] = used[k] | val_q[i][k];
            end
        end
        ev_hit = hit_of(ev_group);
        ev_sel = first((|ev_hit) ? ev_hit : ~used);
    end
    assign ev_ready = (|ev_hit) || !(&used);
    assign ev_take = en && ev_valid && ev_ready;

    // one-second tick shared by group, source and query timers
    always_ff @(posedge clock) begin
        if (rst) begin
            tcnt_q <= 32'h0000_0000;
        end else if (en) begin
            tcnt_q <= tick ? 32'h0000_0000 : tcnt_q + 32'h0000_0001;
        end
    end
    assign tick = tcnt_q == 32'(TICK_CYC - 1);

    // per-interface records; a report in the same cycle beats expiry
    always_ff @(posedge clock) begin
        if (rst) begin
            val_q <= '0;
            v1_q <= '0;
            excl_q <= '0;
            sok_q <= '0;
            for (int i = 0; i < NC; i++) begin
                for (int k = 0; k < NS; k++) begin
                    gt_q[i][k] <= mcast_pkg::T_ZERO;
                    st_q[i][k] <= mcast_pkg::T_ZERO;
                    src_q[i][k] <= '0;
                end
            end
        end else if (en) begin
            for (int i = 0; i < NC; i++) begin
                for (int k = 0; k < NS; k++) begin
                    if (tick && val_q[i][k]) begin
                        if (gt_q[i][k] == mcast_pkg::T_ONE ||
                            (!excl_q[i][k] && st_q[i][k] == mcast_pkg::T_ONE)) begin
                            val_q[i][k] <= 1'b0;
                        end
                        if (gt_q[i][k] != mcast_pkg::T_ZERO) begin
                            gt_q[i][k] <= gt_q[i][k] - mcast_pkg::T_ONE;
                        end
                        if (st_q[i][k] != mcast_pkg::T_ZERO) begin
                            st_q[i][k] <= st_q[i][k] - mcast_pkg::T_ONE;
                        end
                    end
                    if (ev_take && ev_ifc == mcast_pkg::CW'(i) && ev_sel == mcast_pkg::SW'(k)) begin
                        val_q[i][k] <= !ev_leave;
                        v1_q[i][k] <= ev_v1;
                        excl_q[i][k] <= ev_v1 | ev_excl;
                        sok_q[i][k] <= ev_src_ok & !ev_v1;
                        src_q[i][k] <= ev_src;
                        gt_q[i][k] <= mcast_pkg::GMI_T;
                        st_q[i][k] <= (ev_v1 | ev_excl) ? mcast_pkg::T_ZERO : mcast_pkg::GMI_T;
                    end
                end
            end
        end
    end

    // group address of a newly allocated slot
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int k = 0; k < NS; k++) begin
                grp_q[k] <= '0;
            end
        end else if (ev_take && !(|ev_hit)) begin
            grp_q[ev_sel] <= ev_group;
        end
    end

    // merge: timers never leave this process, only presence, mode and sources do
    always_comb begin
        xs = '0;
        xf = 1'b0;
        xok = 1'b0;
        for (int k = 0; k < NS; k++) begin
            mdb_d[k] = '0;
            xs = '0;
            xf = 1'b0;
            xok = 1'b1;
            for (int i = 0; i < NC; i++) begin
                if (val_q[i][k]) begin
                    mdb_d[k].on = 1'b1;
                    if (excl_q[i][k]) begin
                        mdb_d[k].excl = 1'b1;
                        if (!xf) begin
                            xs = src_q[i][k];
                        end
                        xf = 1'b1;
                        // sources with a running timer are requested, not blocked
                        xok = xok && sok_q[i][k] && st_q[i][k] == mcast_pkg::T_ZERO && src_q[i][k] == xs;
                    end else if (sok_q[i][k] && st_q[i][k] != mcast_pkg::T_ZERO) begin
                        mdb_d[k].ok[i] = 1'b1;
                        mdb_d[k].src[i] = src_q[i][k];
                    end
                end
            end
            if (mdb_d[k].excl) begin
                for (int i = 0; i < NC; i++) begin
                    if (mdb_d[k].ok[i] && mdb_d[k].src[i] == xs) begin
                        xok = 1'b0;
                    end
                end
                mdb_d[k].ok = '0;
                mdb_d[k].src = '0;
                mdb_d[k].ok[0] = xok;
                mdb_d[k].src[0] = xok ? xs : '0;
            end
        end
    end

    // merged table and change detection
    always_ff @(posedge clock) begin
        for (int k = 0; k < NS; k++) begin
            if (rst) begin
                mdb_q[k] <= '0;
            end else if (en) begin
                mdb_q[k] <= mdb_d[k];
            end
        end
    end
    always_comb begin
        for (int k = 0; k < NS; k++) begin
            chg[k] = en && mdb_d[k] != mdb_q[k];
            on_q[k] = mdb_q[k].on;
        end
    end

    // pending reports; a new cause wins over the clear of a sent one
    always_ff @(posedge clock) begin
        if (rst) begin
            un_q <= '0;
            so_q <= '0;
        end else if (en) begin
            un_q <= (un_q & ~sent) | chg;
            so_q <= ((so_q & ~sent) | {NS{uq_valid}}) & on_q;
        end
    end
    assign pend = un_q | so_q;
    assign rk = first(pend);
    assign load = en && (!rp_valid_q || rp_ready) && (|pend);
    assign sent = load ? (NS'(1) << rk) : '0;

    // report output register; a removed group leaves as include-nothing
    always_ff @(posedge clock) begin
        if (rst) begin
            rp_valid_q <= 1'b0;
            rp_group_q <= '0;
            rp_excl_q <= 1'b0;
            rp_ok_q <= '0;
            rp_src_q <= '0;
            rp_sol_q <= 1'b0;
            rp_v1_q <= 1'b0;
        end else if (en && (!rp_valid_q || rp_ready)) begin
            rp_valid_q <= |pend;
            if (|pend) begin
                rp_group_q <= grp_q[rk];
                rp_excl_q <= mdb_q[rk].excl;
                rp_ok_q <= mdb_q[rk].ok;
                rp_src_q <= mdb_q[rk].src;
                rp_sol_q <= !un_q[rk];
                rp_v1_q <= up_v1;
            end
        end
    end
    assign rp_valid = rp_valid_q;
    assign rp_group = rp_group_q;
    assign rp_excl = rp_excl_q;
    assign rp_src_ok = rp_ok_q;
    assign rp_src = rp_src_q;
    assign rp_solicited = rp_sol_q;
    assign rp_v1 = rp_v1_q;

    // general queries on customer side only; foreign queriers are not watched
    always_ff @(posedge clock) begin
        if (rst) begin
            qcnt_q <= mcast_pkg::Q_FIRST;
            qry_q <= '0;
        end else if (en) begin
            qry_q <= '0;
            if (tick) begin
                if (qcnt_q == mcast_pkg::T_ONE) begin
                    qry_q <= '1;
                    qcnt_q <= mcast_pkg::QI_T;
                end else begin
                    qcnt_q <= qcnt_q - mcast_pkg::T_ONE;
                end
            end
        end
    end
    assign qry_pulse = qry_q;

    // forwarding decision per packet header
    always_comb begin
        pk_hit = hit_of(pk_dst);
        lnk = pk_dst[AW-1 -: 16] == mcast_pkg::LINK_SCOPE;
        site = pk_dst[AW-1 -: 16] == mcast_pkg::SITE_SCOPE;
        mask_d = '0;
        loc_d = 1'b0;
        for (int i = 0; i < NC; i++) begin
            mem[i] = 1'b0;
            for (int k = 0; k < NS; k++) begin
                if (pk_hit[k] && val_q[i][k]) begin
                    if (sok_q[i][k] && src_q[i][k] == pk_src) begin
                        mem[i] = st_q[i][k] != mcast_pkg::T_ZERO;
                    end else begin
                        mem[i] = excl_q[i][k];
                    end
                end
            end
        end
        if (pk_mld || lnk) begin
            loc_d = 1'b1;
        end else if (site) begin
            if (pk_ifc != mcast_pkg::IFC_UP) begin
                mask_d[NC:1] = '1;
            end
        end else begin
            mask_d[0] = pk_ifc != mcast_pkg::IFC_UP;
            mask_d[NC:1] = mem;
        end
        if (!(pk_mld || lnk)) begin
            mask_d[pk_ifc] = 1'b0;
        end
    end

    // two-entry decision buffer: a stalled receiver back-pressures the parser
    assign pk_ready = cnt_q != mcast_pkg::BUF_FULL;
    assign pk_take = en && pk_valid && pk_ready;
    assign fwd_valid = cnt_q != 2'h0;
    assign pop = en && fwd_valid && fwd_ready;
    always_ff @(posedge clock) begin
        if (rst) begin
            wp_q <= 1'b0;
            rdp_q <= 1'b0;
            cnt_q <= 2'h0;
            fb_loc_q <= 2'h0;
            fb_mask_q[0] <= '0;
            fb_mask_q[1] <= '0;
        end else if (en) begin
            if (pk_take) begin
                fb_mask_q[wp_q] <= mask_d;
                fb_loc_q[wp_q] <= loc_d;
                wp_q <= !wp_q;
            end
            if (pop) begin
                rdp_q <= !rdp_q;
            end
            cnt_q <= cnt_q + 2'(pk_take) - 2'(pop);
        end
    end
    assign fwd_mask = fb_mask_q[rdp_q];
    assign fwd_local = fb_loc_q[rdp_q];

    a_no_ingress: assert property (@(posedge clock) disable iff (rst)
        pk_take |-> !mask_d[pk_ifc]) else $error("packet sent back to ingress");
    a_link_local: assert property (@(posedge clock) disable iff (rst)
        pk_take && lnk |-> mask_d == '0 && loc_d) else $error("link scope left interface");
    a_mld_relay: assert property (@(posedge clock) disable iff (rst)
        pk_take && pk_mld |-> mask_d == '0) else $error("listener message relayed");
    a_site_up: assert property (@(posedge clock) disable iff (rst)
        pk_take && site && !pk_mld |-> !mask_d[0] && (pk_ifc == mcast_pkg::IFC_UP || mask_d != '0))
        else $error("site scope misrouted");
    a_up_global: assert property (@(posedge clock) disable iff (rst)
        pk_take && !lnk && !site && !pk_mld && pk_ifc != mcast_pkg::IFC_UP |=> fwd_valid)
        else $error("upstream decision lost");
    a_v1_convert: assert property (@(posedge clock) disable iff (rst)
        ev_take && ev_v1 && !ev_leave |=> val_q[$past(ev_ifc)][$past(ev_sel)] &&
        excl_q[$past(ev_ifc)][$past(ev_sel)] && !sok_q[$past(ev_ifc)][$past(ev_sel)])
        else $error("old report not converted");
    // an old-version group must keep its exclude-nothing form for as long as it lives
    a_v1_mode: assert property (@(posedge clock) disable iff (rst)
        (val_q & v1_q & ~excl_q) == '0 && (val_q & v1_q & sok_q) == '0)
        else $error("old-version record not in exclude form");
    a_chg_report: assert property (@(posedge clock) disable iff (rst)
        (|chg) |=> (un_q & $past(chg)) == $past(chg)) else $error("change without report");
    a_query_pulse: assert property (@(posedge clock) disable iff (rst)
        qry_pulse != '0 |-> qry_pulse == '1 ##1 qry_pulse == '0) else $error("bad query pulse");
    a_rp_hold: assert property (@(posedge clock) disable iff (rst)
        rp_valid && !rp_ready |=> rp_valid && $stable(rp_group) && $stable(rp_solicited))
        else $error("report dropped under stall");
    a_buf_full: assert property (@(posedge clock) disable iff (rst)
        cnt_q == mcast_pkg::BUF_FULL |-> !pk_ready ##1 cnt_q != 2'h3) else $error("buffer overflow");
    c_site_pkt: cover property (@(posedge clock) disable iff (rst) pk_take && site);
    c_solicited: cover property (@(posedge clock) disable iff (rst) rp_valid && rp_ready && rp_solicited);
    c_buf_stall: cover property (@(posedge clock) disable iff (rst) pk_valid && !pk_ready);
    c_merge_excl: cover property (@(posedge clock) disable iff (rst) (|chg) ##2 rp_valid && rp_excl);
endmodule

//--- inc/mcast_pkg.sv
/*
 * Shared constants and types for the multicast proxy and forwarder.
 * Assumes one 100 MHz clock; every timer counts one-second ticks.
 */
package mcast_pkg;
    localparam int NCFI = 2;
    localparam int NSLOT = 4;
    localparam int AW = 128;
    localparam int SW = 2;
    localparam int CW = 1;
    localparam int IW = 2;
    localparam int CLK_NS = 10;
    localparam int TICK_NS = 1_000_000_000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int GMI_S = 260;
    localparam int QI_S = 125;
    localparam logic [8:0] GMI_T = 9'(GMI_S);
    localparam logic [8:0] QI_T = 9'(QI_S);
    localparam logic [8:0] T_ONE = 9'h001;
    localparam logic [8:0] T_ZERO = 9'h000;
    localparam logic [8:0] Q_FIRST = 9'h001;
    localparam logic [15:0] LINK_SCOPE = 16'hFF02;
    localparam logic [15:0] SITE_SCOPE = 16'hFF05;
    localparam logic [IW-1:0] IFC_UP = 2'h0;
    localparam logic [1:0] BUF_FULL = 2'h2;
    // one merged membership entry: no timers are carried
    typedef struct packed {
        logic on;
        logic excl;
        logic [NCFI-1:0] ok;
        logic [NCFI-1:0][AW-1:0] src;
    } mrec_t;
endpackage

//--- verif/mcast_far_model.sv
/*
 * Far-side model: the upstream router that takes reports and the egress
 * ports that take forwarding decisions.
 * Assumes the proxy offers both streams with valid/ready and holds them.
 */
`timescale 1ns/1ps
module mcast_far_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] mode,
    output logic rp_ready,
    output logic fwd_ready
);
    logic [1:0] beat_q;
    logic go;
    // free beat counter paces the slow mode
    always_ff @(posedge clock) begin
        if (rst) begin
            beat_q <= 2'h0;
        end else begin
            beat_q <= beat_q + 2'h1;
        end
    end
    // mode 0 prompt, 1 one cycle in four, 2 held off to back the buffer up
    assign go = (mode == 2'h0) || (mode == 2'h1 && beat_q == 2'h3);
    // registered so ready never leans on valid in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            rp_ready <= 1'b0;
            fwd_ready <= 1'b0;
        end else begin
            rp_ready <= go;
            fwd_ready <= go;
        end
    end
endmodule

//--- verif/testbench.sv
/*
 * Self-checking bench for the multicast proxy: joins, leaves, queries,
 * forwarding decisions, scope handling and the decision buffer.
 * Assumes mcast_far_model sits on the report and decision outputs.
 */
`timescale 1ns/1ps
module testbench;
    logic clock = 0, rst = 1, en = 1, ev_valid = 0, ev_v1 = 0, ev_excl = 0, ev_leave = 0, ev_src_ok = 0;
    logic uq_valid = 0, up_v1 = 0, pk_valid = 0, pk_mld = 0, ev_ready, rp_valid, rp_ready, rp_excl;
    logic rp_solicited, rp_v1, pk_ready, fwd_valid, fwd_ready, fwd_local;
    logic [mcast_pkg::CW-1:0] ev_ifc = '0;
    logic [mcast_pkg::AW-1:0] ev_group = '0, ev_src = '0, pk_dst = '0, pk_src = '0, rp_group;
    logic [mcast_pkg::NCFI-1:0] rp_src_ok, qry_pulse;
    logic [mcast_pkg::NCFI-1:0][mcast_pkg::AW-1:0] rp_src;
    logic [mcast_pkg::IW-1:0] pk_ifc = '0;
    logic [mcast_pkg::NCFI:0] fwd_mask;
    logic [1:0] far_mode = 2'h0;
    int n_errors = 0, check_count = 0;
    localparam logic [127:0] G100 = {16'hFF1E, 112'h100};
    localparam logic [127:0] G128 = {16'hFF1E, 112'h128};
    localparam logic [127:0] G200 = {16'hFF1E, 112'h200};
    localparam logic [127:0] S100 = {32'h3FFE_2900, 96'h100};
    localparam logic [127:0] S200 = {32'h3FFE_2900, 96'h200};
    always #5 clock = ~clock;
    // short tick keeps the query timer inside the run
    mcast_proxy #(.TICK_CYC(20)) u_mcast_proxy (.clock(clock), .rst(rst), .en(en),
        .ev_valid(ev_valid), .ev_ready(ev_ready), .ev_ifc(ev_ifc), .ev_group(ev_group), .ev_v1(ev_v1),
        .ev_excl(ev_excl), .ev_leave(ev_leave), .ev_src(ev_src), .ev_src_ok(ev_src_ok),
        .uq_valid(uq_valid), .up_v1(up_v1), .rp_valid(rp_valid), .rp_ready(rp_ready),
        .rp_group(rp_group), .rp_excl(rp_excl), .rp_src_ok(rp_src_ok), .rp_src(rp_src),
        .rp_solicited(rp_solicited), .rp_v1(rp_v1), .qry_pulse(qry_pulse), .pk_valid(pk_valid),
        .pk_ready(pk_ready), .pk_ifc(pk_ifc), .pk_dst(pk_dst), .pk_src(pk_src), .pk_mld(pk_mld),
        .fwd_valid(fwd_valid), .fwd_ready(fwd_ready), .fwd_mask(fwd_mask), .fwd_local(fwd_local));
    mcast_far_model u_mcast_far_model (.clock(clock), .rst(rst), .mode(far_mode),
        .rp_ready(rp_ready), .fwd_ready(fwd_ready));

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // waits at falling edges so the accept edge is the next rising one
    task automatic wait_acc(input bit fwd);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (!(fwd ? (fwd_valid && fwd_ready) : (rp_valid && rp_ready)) && n < 400);
        check("handshake", 128'(fwd ? (fwd_valid && fwd_ready) : (rp_valid && rp_ready)), 128'h1);
    endtask
    task automatic send_ev(input logic ifc, input logic [127:0] grp, input logic v1, excl, leave,
        input logic [127:0] src);
        @(posedge clock);
        ev_valid <= 1'b1;
        ev_ifc <= ifc;
        ev_group <= grp;
        ev_v1 <= v1;
        ev_excl <= excl;
        ev_leave <= leave;
        ev_src <= src;
        ev_src_ok <= (src != '0);
        do @(negedge clock); while (ev_ready !== 1'b1);
        @(posedge clock);
        ev_valid <= 1'b0;
    endtask
    task automatic expect_rp(input logic [127:0] grp, input logic excl, sol, input logic [1:0] ok);
        wait_acc(0);
        check("rp_group", rp_group, grp);
        check("rp_excl", 128'(rp_excl), 128'(excl));
        check("rp_solicited", 128'(rp_solicited), 128'(sol));
        check("rp_src_ok", 128'(rp_src_ok), 128'(ok));
        check("rp_v1", 128'(rp_v1), 128'(up_v1));
    endtask
    task automatic send_pkt(input logic [1:0] ifc, input logic [127:0] dst, src, input logic mld);
        @(posedge clock);
        pk_valid <= 1'b1;
        pk_ifc <= ifc;
        pk_dst <= dst;
        pk_src <= src;
        pk_mld <= mld;
        do @(negedge clock); while (pk_ready !== 1'b1);
        @(posedge clock);
        pk_valid <= 1'b0;
    endtask
    task automatic expect_fwd(input logic [2:0] mask, input logic loc);
        wait_acc(1);
        check("fwd_mask", 128'(fwd_mask), 128'(mask));
        check("fwd_local", 128'(fwd_local), 128'(loc));
    endtask

    task automatic t_reset();
        @(negedge clock);
        check("ev_ready", 128'(ev_ready), 128'h1);
        check("pk_ready", 128'(pk_ready), 128'h1);
        check("idle outputs", 128'({rp_valid, fwd_valid, qry_pulse}), 128'h0);
        $display("test reset done");
    endtask
    task automatic t_query_tick();
        int n;
        n = 0;
        while (qry_pulse === 2'h0 && n < 80) begin
            @(negedge clock);
            n++;
        end
        check("qry_pulse", 128'(qry_pulse), 128'h3);
        $display("test query tick done");
    endtask
    task automatic t_join();
        send_ev(0, G100, 1, 0, 0, '0);
        expect_rp(G100, 1, 0, 2'h0);
        send_ev(0, G128, 0, 1, 0, '0);
        expect_rp(G128, 1, 0, 2'h0);
        send_ev(1, G128, 0, 1, 0, S200);
        repeat (40) @(posedge clock);
        $display("test join done");
    endtask
    // answers come out while the upstream side stalls
    task automatic t_query();
        far_mode <= 2'h1;
        @(posedge clock);
        uq_valid <= 1'b1;
        @(posedge clock);
        uq_valid <= 1'b0;
        expect_rp(G100, 1, 1, 2'h0);
        expect_rp(G128, 1, 1, 2'h0);
        far_mode <= 2'h0;
        $display("test query done");
    endtask
    task automatic t_fwd_example();
        logic [127:0] d [4] = '{{16'hFF1E, 112'h200}, G100, G128, G128};
        logic [127:0] s [4] = '{S100, S100, S100, S200};
        logic [2:0] m [4] = '{3'h0, 3'h2, 3'h6, 3'h2};
        for (int i = 0; i < 4; i++) begin
            send_pkt(2'h0, d[i], s[i], 1'b0);
            expect_fwd(m[i], 1'b0);
        end
        $display("test forwarding example done");
    endtask
    task automatic t_scope();
        logic [1:0] f [6] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h1, 2'h2};
        logic [127:0] d [6] = '{{16'hFF02, 112'h1}, {16'hFF05, 112'h1}, {16'hFF05, 112'h1}, G128,
            {16'hFF1E, 112'h300}, G128};
        logic k [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        logic [2:0] m [6] = '{3'h0, 3'h4, 3'h0, 3'h0, 3'h1, 3'h3};
        logic l [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 6; i++) begin
            send_pkt(f[i], d[i], S100, k[i]);
            expect_fwd(m[i], l[i]);
        end
        $display("test scope done");
    endtask
    // two decisions queue while the egress side is held off
    task automatic t_buffer();
        far_mode <= 2'h2;
        send_pkt(2'h1, {16'hFF02, 112'h1}, S100, 1'b0);
        send_pkt(2'h2, {16'hFF05, 112'h1}, S100, 1'b0);
        @(negedge clock);
        check("pk_ready full", 128'(pk_ready), 128'h0);
        far_mode <= 2'h0;
        expect_fwd(3'h0, 1'b1);
        expect_fwd(3'h2, 1'b0);
        @(negedge clock);
        check("fwd_valid empty", 128'(fwd_valid), 128'h0);
        $display("test buffer done");
    endtask
    task automatic t_leave();
        up_v1 <= 1'b1;
        send_ev(0, G100, 0, 0, 1, '0);
        expect_rp(G100, 0, 0, 2'h0);
        send_pkt(2'h0, G100, S100, 1'b0);
        expect_fwd(3'h0, 1'b0);
        up_v1 <= 1'b0;
        $display("test leave done");
    endtask
    // an include join names its source; only that source is passed down
    task automatic t_include();
        send_ev(1, G200, 0, 0, 0, S100);
        expect_rp(G200, 0, 0, 2'h2);
        check("rp_src", rp_src[1], S100);
        send_pkt(2'h0, G200, S100, 1'b0);
        expect_fwd(3'h4, 1'b0);
        send_pkt(2'h0, G200, S200, 1'b0);
        expect_fwd(3'h0, 1'b0);
        $display("test include done");
    endtask
    // a reset in mid-run must leave no joined group behind
    task automatic t_mid_reset();
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        send_pkt(2'h0, G128, S100, 1'b0);
        expect_fwd(3'h0, 1'b0);
        send_pkt(2'h0, G200, S100, 1'b0);
        expect_fwd(3'h0, 1'b0);
        $display("test mid-run reset done");
    endtask
    // with the enable low an offered packet is not taken
    task automatic t_enable();
        @(posedge clock);
        en <= 1'b0;
        send_pkt(2'h1, G200, S100, 1'b0);
        @(negedge clock);
        check("fwd_valid frozen", 128'(fwd_valid), 128'h0);
        @(posedge clock);
        en <= 1'b1;
        send_pkt(2'h1, G200, S100, 1'b0);
        expect_fwd(3'h1, 1'b0);
        $display("test enable done");
    endtask

    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_query_tick();
        t_join();
        t_query();
        t_fwd_example();
        t_scope();
        t_buffer();
        t_leave();
        t_include();
        t_mid_reset();
        t_enable();
        give_verdict();
    end
    // the whole sequence needs well under a twentieth of this span
    initial begin
        repeat (40000) @(posedge clock);
        n_errors++;
        give_verdict();
    end
endmodule
